// ==== common/bobd_defs.vh ====
// Purpose: shared constants of the bit-operation and branch decoder
// Assumes: 16-bit instruction words, byte-addressed program counter
// Notes: included by bare name from every design file
//
// Behaviour
// - branch phases: decode, read offset, process, load PC
// - branch target is PC plus 2 plus 2n
// - opcode 1000 sets chosen bit of file
// - access flag picks access bank or bank select
// - flag zero, extended, low address: indexed offset
// - bit set is one cycle, read-modify-write
// - opcode 1011 skips next when bit clear
// - skip flushes prefetched word, runs one no-op
// - skip over two-word instruction takes three cycles
`ifndef BOBD_DEFS_VH
`define BOBD_DEFS_VH

// q phase codes inside one instruction cycle
`define BOBD_Q1 2'h0
`define BOBD_Q2 2'h1
`define BOBD_Q3 2'h2
`define BOBD_Q4 2'h3

// opcode field, instruction bits 15:12
`define BOBD_OP_SET_BIT 4'h8
`define BOBD_OP_TEST_CLR 4'hB
`define BOBD_OP_BRANCH 4'hD
// bit 11 must be clear for the relative branch
`define BOBD_BRANCH_SUB_BIT 11

// field positions
`define BOBD_OP_HI 15
`define BOBD_OP_LO 12
`define BOBD_BIT_HI 11
`define BOBD_BIT_LO 9
`define BOBD_ACCESS_BIT 8
`define BOBD_FILE_HI 7
`define BOBD_FILE_LO 0
`define BOBD_OFS_HI 10

// access bank split and indexed window
`define BOBD_ACCESS_SPLIT 8'h60
`define BOBD_INDEXED_MAX 8'h5F
`define BOBD_ACCESS_LO_BANK 4'h0
`define BOBD_ACCESS_HI_BANK 4'hF

// extra no-op instruction cycles
`define BOBD_NOP_BRANCH 2'h1
`define BOBD_NOP_SKIP 2'h1
`define BOBD_NOP_SKIP_LONG 2'h2

// program counter step over the current word
`define BOBD_PC_STEP 2'h2

// state machine codes
`define BOBD_ST_EXEC 1'b0
`define BOBD_ST_NOP 1'b1

`endif

// ==== hw/bobd_qphase.v ====
// Purpose: splits the system clock into four q phases
// Assumes: one instruction cycle is four clock cycles
// Notes: phase is a plain counter, the decoder compares against it
`timescale 1ns/100ps
`include "bobd_defs.vh"

module bobd_qphase (
    input wire clk_i,
    input wire rst_i,
    output wire [1:0] phase_o,
    output wire q4_o
);

    reg [1:0] phase_q;
    wire [1:0] phase_d;

    // wraps naturally from q4 back to q1
    assign phase_d = phase_q + 2'h1;

    // counter restarts at q1 on reset
    always @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= `BOBD_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase_o = phase_q;
    assign q4_o = (phase_q == `BOBD_Q4);

endmodule

// ==== hw/bobd_decoder.v ====
// Purpose: decode and q-phase control for relative branch, bit set, bit test skip
// Assumes: instruction word, pc and file read data valid in the phase sampled
// Notes: file memory, status register and fetch unit live outside;
//   the q counter keeps running through forced no-op cycles
`timescale 1ns/100ps
`include "bobd_defs.vh"

module bobd_decoder #(
    parameter PC_W = 21
) (
    input wire CLK_I,
    input wire RST_I,
    input wire [15:0] INSTR_I,
    input wire NEXT_TWO_WORD_I,
    input wire [PC_W-1:0] PC_I,
    input wire EXT_EN_I,
    input wire [5:0] BSR_I,
    input wire [11:0] FSR2_I,
    input wire [7:0] RD_DATA_I,
    output wire [1:0] Q_PHASE_O,
    output wire INSTR_TAKE_O,
    output wire NOP_CYCLE_O,
    output wire [11:0] FILE_ADDR_O,
    output wire FILE_RD_O,
    output wire FILE_WR_O,
    output wire [7:0] FILE_WDATA_O,
    output wire PC_LOAD_O,
    output wire [PC_W-1:0] PC_NEW_O,
    output wire FLUSH_O,
    output wire STATUS_WE_O
);

    wire [1:0] phase;
    wire q4;

    // pipeline state held across the four q phases
    reg state_q;
    reg [1:0] nop_cnt_q;
    reg [15:0] ir_q;
    reg two_word_q;
    reg [PC_W-1:0] pc_base_q;
    reg [11:0] addr_q;
    reg rd_q;
    reg [7:0] rdat_q;
    reg wr_q;
    reg [7:0] wdata_q;
    reg pc_load_q;
    reg [PC_W-1:0] pc_new_q;
    reg flush_q;
    reg skip_q;

    // combinational next values
    reg [11:0] addr_d;
    reg [PC_W-1:0] target_d;
    reg [7:0] mask_d;

    // decode helpers
    wire [3:0] opcode;
    wire is_set;
    wire is_test;
    wire is_branch;
    wire in_op_set;
    wire in_op_test;
    wire exec;
    wire [7:0] in_file;
    wire in_banked;
    wire in_indexed;
    wire in_upper;
    wire tested_clear;
    wire nop_done;
    wire [PC_W-1:0] pc_step;
    wire [PC_W-1:0] ofs_twice;

    bobd_qphase u_qphase (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .phase_o(phase),
        .q4_o(q4)
    );

    assign exec = (state_q == `BOBD_ST_EXEC);

    // decode of the latched word, used from q2 onward
    assign opcode = ir_q[`BOBD_OP_HI:`BOBD_OP_LO];
    assign is_set = (opcode == `BOBD_OP_SET_BIT);
    assign is_test = (opcode == `BOBD_OP_TEST_CLR);
    assign is_branch = (opcode == `BOBD_OP_BRANCH) && !ir_q[`BOBD_BRANCH_SUB_BIT];

    // early decode of the incoming word, so the read can start in q2
    assign in_op_set = (INSTR_I[`BOBD_OP_HI:`BOBD_OP_LO] == `BOBD_OP_SET_BIT);
    assign in_op_test = (INSTR_I[`BOBD_OP_HI:`BOBD_OP_LO] == `BOBD_OP_TEST_CLR);

    // address mode of the incoming word, access flag decides first
    assign in_file = INSTR_I[`BOBD_FILE_HI:`BOBD_FILE_LO];
    assign in_banked = INSTR_I[`BOBD_ACCESS_BIT];
    assign in_indexed = EXT_EN_I && (in_file <= `BOBD_INDEXED_MAX);
    assign in_upper = (in_file >= `BOBD_ACCESS_SPLIT);

    // file address of the incoming word; only bank select,
    // access bank or indexed window, never a status side path
    always @* begin
        addr_d = 12'h000;
        if (in_banked) begin
            addr_d = {BSR_I[3:0], in_file};
        end else if (in_indexed) begin
            addr_d = FSR2_I + {4'h0, in_file};
        end else if (in_upper) begin
            addr_d = {`BOBD_ACCESS_HI_BANK, in_file};
        end else begin
            addr_d = {`BOBD_ACCESS_LO_BANK, in_file};
        end
    end

    // step over the branch word and the doubled signed offset, both pc wide
    assign pc_step = {{(PC_W-2){1'b0}}, `BOBD_PC_STEP};
    assign ofs_twice = {{(PC_W-12){ir_q[`BOBD_OFS_HI]}}, ir_q[`BOBD_OFS_HI:0], 1'b0};

    // branch target and bit mask from the latched word
    always @* begin
        target_d = pc_base_q + pc_step + ofs_twice;
        mask_d = 8'h01 << ir_q[`BOBD_BIT_HI:`BOBD_BIT_LO];
    end

    // tested bit reads as zero; one term feeds skip and flush alike
    assign tested_clear = ((rdat_q & mask_d) == 8'h00);

    // last q4 of the forced no-op run, q4 pulse from the phase divider
    assign nop_done = q4 && !exec && (nop_cnt_q == 2'h1);

    // q-phase sequencer; wide bank number above 4 bits and the indexed sum carry are cut
    // on purpose, the data space is 12 bits
    always @(posedge CLK_I) begin
        if (RST_I) begin
            state_q <= `BOBD_ST_EXEC;
            nop_cnt_q <= 2'h0;
            ir_q <= 16'h0000;
            two_word_q <= 1'b0;
            pc_base_q <= {PC_W{1'b0}};
            addr_q <= 12'h000;
            rd_q <= 1'b0;
            rdat_q <= 8'h00;
            wr_q <= 1'b0;
            wdata_q <= 8'h00;
            pc_load_q <= 1'b0;
            pc_new_q <= {PC_W{1'b0}};
            flush_q <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            case (phase)
                `BOBD_Q1: begin
                    // decode: take word, raise read for the bit forms
                    if (exec) begin
                        ir_q <= INSTR_I;
                        two_word_q <= NEXT_TWO_WORD_I;
                        pc_base_q <= PC_I;
                        addr_q <= addr_d;
                        rd_q <= in_op_set || in_op_test;
                    end else begin
                        // no-op cycle keeps a harmless word latched
                        ir_q <= 16'h0000;
                        rd_q <= 1'b0;
                    end
                end
                `BOBD_Q2: begin
                    // read register or literal offset
                    rd_q <= 1'b0;
                    rdat_q <= RD_DATA_I;
                end
                `BOBD_Q3: begin
                    // process: modify, test, or form branch target
                    wdata_q <= rdat_q | mask_d;
                    wr_q <= exec && is_set;
                    skip_q <= exec && is_test && tested_clear;
                    flush_q <= exec && (is_branch || (is_test && tested_clear));
                    pc_load_q <= exec && is_branch;
                    pc_new_q <= target_d;
                end
                default: begin
                    // q4: write-back and pc load end, pick next cycle kind;
                    // a skipped two-word instruction costs a second no-op,
                    // as its trailing word is never decoded here
                    wr_q <= 1'b0;
                    pc_load_q <= 1'b0;
                    flush_q <= 1'b0;
                    skip_q <= 1'b0;
                    if (exec) begin
                        if (is_branch) begin
                            state_q <= `BOBD_ST_NOP;
                            nop_cnt_q <= `BOBD_NOP_BRANCH;
                        end else if (skip_q) begin
                            state_q <= `BOBD_ST_NOP;
                            nop_cnt_q <= two_word_q ? `BOBD_NOP_SKIP_LONG
                                : `BOBD_NOP_SKIP;
                        end
                    end else if (nop_done) begin
                        state_q <= `BOBD_ST_EXEC;
                        nop_cnt_q <= 2'h0;
                    end else begin
                        nop_cnt_q <= nop_cnt_q - 2'h1;
                    end
                end
            endcase
        end
    end

    // fetch side sees the word taken only in an executing q1;
    // the strobe already shows during reset, since reset lands in q1
    assign INSTR_TAKE_O = exec && (phase == `BOBD_Q1);
    assign NOP_CYCLE_O = !exec;
    assign Q_PHASE_O = phase;

    // file port: address stands until the next take, strobes one clock
    assign FILE_ADDR_O = addr_q;
    assign FILE_RD_O = rd_q;
    assign FILE_WR_O = wr_q;
    assign FILE_WDATA_O = wdata_q;

    // pc port: target only meaningful while the load strobe is high
    assign PC_LOAD_O = pc_load_q;
    assign PC_NEW_O = pc_new_q;
    assign FLUSH_O = flush_q;

    // status flags are never written by these instructions
    assign STATUS_WE_O = 1'b0;

endmodule

// ==== test/bobd_decoder_assertions.sv ====
// Purpose: port-level property checks for the bit-op and branch decoder
// Assumes: one clock, synchronous active-high reset
// Notes: attached to every decoder instance by the bind at the foot
`timescale 1ns/100ps
module bobd_checker #(
    parameter PC_W = 21
) (
    input wire CLK_I,
    input wire RST_I,
    input wire [15:0] INSTR_I,
    input wire NEXT_TWO_WORD_I,
    input wire [PC_W-1:0] PC_I,
    input wire EXT_EN_I,
    input wire [5:0] BSR_I,
    input wire [11:0] FSR2_I,
    input wire [7:0] RD_DATA_I,
    input wire [1:0] Q_PHASE_O,
    input wire INSTR_TAKE_O,
    input wire NOP_CYCLE_O,
    input wire [11:0] FILE_ADDR_O,
    input wire FILE_RD_O,
    input wire FILE_WR_O,
    input wire [7:0] FILE_WDATA_O,
    input wire PC_LOAD_O,
    input wire [PC_W-1:0] PC_NEW_O,
    input wire FLUSH_O,
    input wire STATUS_WE_O
);
    // decoded takes; target sign-extends twice the offset
    wire tk = INSTR_TAKE_O;
    wire st = tk && INSTR_I[15:12] == 4'h8;
    wire bt = st || (tk && INSTR_I[15:12] == 4'hB);
    wire br = tk && INSTR_I[15:12] == 4'hD && !INSTR_I[11];
    wire [PC_W-1:0] tgt = PC_I + 2 + {{(PC_W-12){INSTR_I[10]}}, INSTR_I[10:0], 1'b0};
    // indexed address wraps inside the 12-bit data space
    wire [11:0] idx = FSR2_I + {4'h0, INSTR_I[7:0]};
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // test take followed by the tested bit read back at the end of q2
    sequence tst_clr;
        tk && INSTR_I[15:12] == 4'hB ##1 !RD_DATA_I[$past(INSTR_I[11:9])];
    endsequence
    sequence tst_clr_long;
        tk && INSTR_I[15:12] == 4'hB && NEXT_TWO_WORD_I ##1 !RD_DATA_I[$past(INSTR_I[11:9])];
    endsequence
    sequence tst_set;
        tk && INSTR_I[15:12] == 4'hB ##1 RD_DATA_I[$past(INSTR_I[11:9])];
    endsequence
    a_set_read: assert property (st |=> FILE_RD_O) else $error("no read after bit set");
    a_set_write: assert property (st |-> ##3 FILE_WR_O && FILE_WDATA_O ==
        ($past(RD_DATA_I, 2) | (8'h01 << $past(INSTR_I[11:9], 3)))) else $error("bad write");
    a_bank_sel: assert property (bt && INSTR_I[8] |=>
        FILE_ADDR_O == {$past(BSR_I[3:0]), $past(INSTR_I[7:0])}) else $error("bad bank addr");
    a_indexed_addr: assert property (bt && !INSTR_I[8] && EXT_EN_I && INSTR_I[7:0] <= 8'h5F |=>
        FILE_ADDR_O == $past(idx)) else $error("bad indexed addr");
    a_branch_load: assert property (br |-> ##3 PC_LOAD_O && FLUSH_O &&
        PC_NEW_O == $past(tgt, 3)) else $error("bad branch load");
    a_branch_nop: assert property (br |-> ##4 NOP_CYCLE_O [*4] ##1 tk) else $error("bad nop");
    a_skip_flush: assert property (tst_clr |-> ##2 FLUSH_O ##1 NOP_CYCLE_O [*4])
        else $error("skip not flushed");
    a_skip_long: assert property (tst_clr_long |-> ##3 NOP_CYCLE_O [*8] ##1 tk)
        else $error("long skip length");
    a_no_skip: assert property (tst_set |-> ##2 !FLUSH_O ##1 tk) else $error("false skip");
    a_status_quiet: assert property (!STATUS_WE_O) else $error("status written");
endmodule
bind bobd_decoder bobd_checker #(.PC_W(PC_W)) chk_u (.CLK_I(CLK_I), .RST_I(RST_I),
    .INSTR_I(INSTR_I), .NEXT_TWO_WORD_I(NEXT_TWO_WORD_I), .PC_I(PC_I), .EXT_EN_I(EXT_EN_I),
    .BSR_I(BSR_I), .FSR2_I(FSR2_I), .RD_DATA_I(RD_DATA_I), .Q_PHASE_O(Q_PHASE_O),
    .INSTR_TAKE_O(INSTR_TAKE_O), .NOP_CYCLE_O(NOP_CYCLE_O), .FILE_ADDR_O(FILE_ADDR_O),
    .FILE_RD_O(FILE_RD_O), .FILE_WR_O(FILE_WR_O), .FILE_WDATA_O(FILE_WDATA_O),
    .PC_LOAD_O(PC_LOAD_O), .PC_NEW_O(PC_NEW_O), .FLUSH_O(FLUSH_O), .STATUS_WE_O(STATUS_WE_O));

// ==== test/tb_bit_ops_branch_decoder.sv ====
// Purpose: directed bench for the bit-op and branch decoder
// Assumes: inputs change on the falling edge, 200 MHz clock
// Notes: one word per take, outputs gathered until the next take
`timescale 1ns/100ps
module tb_bit_ops_branch_decoder;
    reg CLK_I = 0, RST_I = 1, NEXT_TWO_WORD_I = 0, EXT_EN_I = 0;
    reg [15:0] INSTR_I = 16'h0000;
    reg [20:0] PC_I = 21'h000000;
    reg [5:0] BSR_I = 6'h00;
    reg [11:0] FSR2_I = 12'h000;
    reg [7:0] RD_DATA_I = 8'h00;
    wire [1:0] Q_PHASE_O;
    wire INSTR_TAKE_O, NOP_CYCLE_O, FILE_RD_O, FILE_WR_O, PC_LOAD_O, FLUSH_O, STATUS_WE_O;
    wire [11:0] FILE_ADDR_O;
    wire [7:0] FILE_WDATA_O;
    wire [20:0] PC_NEW_O;
    integer bad_count = 0, n_compared = 0, cyc;
    reg rdp, wr, ld, fl;
    reg [7:0] wd;
    reg [11:0] ad;
    reg [20:0] pn;
    bobd_decoder #(.PC_W(21)) dut_u (.CLK_I(CLK_I), .RST_I(RST_I), .INSTR_I(INSTR_I),
        .NEXT_TWO_WORD_I(NEXT_TWO_WORD_I), .PC_I(PC_I), .EXT_EN_I(EXT_EN_I), .BSR_I(BSR_I),
        .FSR2_I(FSR2_I), .RD_DATA_I(RD_DATA_I), .Q_PHASE_O(Q_PHASE_O),
        .INSTR_TAKE_O(INSTR_TAKE_O), .NOP_CYCLE_O(NOP_CYCLE_O), .FILE_ADDR_O(FILE_ADDR_O),
        .FILE_RD_O(FILE_RD_O), .FILE_WR_O(FILE_WR_O), .FILE_WDATA_O(FILE_WDATA_O),
        .PC_LOAD_O(PC_LOAD_O), .PC_NEW_O(PC_NEW_O), .FLUSH_O(FLUSH_O), .STATUS_WE_O(STATUS_WE_O));
    // 5 ns period
    initial forever #2.5 CLK_I = ~CLK_I;
    task end_of_test;
        if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected %0s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    // present a word at the take edge, then record outputs up to the next take
    task run(input [15:0] ins, input [20:0] pc, input two, input [7:0] rd);
        cyc = 0;
        while (INSTR_TAKE_O !== 1'b1 && cyc < 20) begin
            @(negedge CLK_I);
            cyc = cyc + 1;
        end
        if (INSTR_TAKE_O !== 1'b1) begin
            bad_count = bad_count + 1;
            end_of_test;
        end
        INSTR_I = ins;
        PC_I = pc;
        NEXT_TWO_WORD_I = two;
        RD_DATA_I = rd;
        @(negedge CLK_I);
        ad = FILE_ADDR_O;
        rdp = FILE_RD_O;
        {wr, ld, fl, wd, pn} = 0;
        for (cyc = 1; cyc < 20 && INSTR_TAKE_O !== 1'b1; cyc = cyc + 1) begin
            if (FILE_WR_O) {wr, wd} = {1'b1, FILE_WDATA_O};
            if (PC_LOAD_O) {ld, pn} = {1'b1, PC_NEW_O};
            if (FLUSH_O) fl = 1;
            @(negedge CLK_I);
        end
        if (cyc == 20) begin
            bad_count = bad_count + 1;
            end_of_test;
        end
    endtask
    // banked bit set, top bit over 0Ah
    task t_set;
        BSR_I = 6'h05;
        run(16'h8F37, 21'h000100, 0, 8'h0A);
        check("addr", ad, 12'h537);
        check("read", rdp, 1);
        check("wdata", wd, 8'h8A);
        check("cycles", cyc, 4);
    endtask
    // indexed window edge, first address past it, then extension off
    task t_addr;
        EXT_EN_I = 1;
        FSR2_I = 12'hFF0;
        run(16'h805F, 21'h000102, 0, 8'h00);
        check("addr", ad, 12'h04F);
        check("wdata", wd, 8'h01);
        run(16'h8060, 21'h000104, 0, 8'h00);
        check("addr", ad, 12'hF60);
        EXT_EN_I = 0;
        run(16'h8010, 21'h000106, 0, 8'h00);
        check("addr", ad, 12'h010);
    endtask
    // bit 3 clear skips one or two words, set does not skip
    task t_skip;
        run(16'hB720, 21'h000108, 0, 8'hF7);
        check("flush", fl, 1);
        check("cycles", cyc, 8);
        run(16'hB720, 21'h00010A, 1, 8'hF7);
        check("cycles", cyc, 12);
        run(16'hB720, 21'h00010C, 1, 8'h08);
        check("flush", fl, 0);
        check("write", wr, 0);
        check("cycles", cyc, 4);
    endtask
    // largest forward offset and an offset of minus one; bit 11 set is not a branch
    task t_branch;
        run(16'hD7FF, 21'h000100, 0, 8'h00);
        check("target", pn, 21'h000100);
        check("flush", fl, 1);
        check("cycles", cyc, 8);
        run(16'hD3FF, 21'h000000, 0, 8'h00);
        check("target", pn, 21'h000800);
        run(16'hD800, 21'h000200, 0, 8'h00);
        check("load", ld, 0);
        check("cycles", cyc, 4);
        check("status", STATUS_WE_O, 0);
    endtask
    // reset inside a branch no-op, then a banked bit set right after release
    task t_reset;
        INSTR_I = 16'hD005;
        repeat (5) @(negedge CLK_I);
        check("nop", NOP_CYCLE_O, 1);
        check("phase", Q_PHASE_O, 1);
        RST_I = 1;
        @(negedge CLK_I);
        RST_I = 0;
        check("phase", Q_PHASE_O, 0);
        check("nop", NOP_CYCLE_O, 0);
        check("take", INSTR_TAKE_O, 1);
        check("load", PC_LOAD_O, 0);
        BSR_I = 6'h0C;
        run(16'h8B41, 21'h000400, 0, 8'h11);
        check("addr", ad, 12'hC41);
        check("wdata", wd, 8'h31);
        check("cycles", cyc, 4);
    endtask
    initial begin
        repeat (10) @(negedge CLK_I);
        RST_I = 0;
        t_set;
        t_addr;
        t_skip;
        t_branch;
        t_reset;
        end_of_test;
    end
endmodule
